// >>> rtl/adcs_pkg.sv
// Constants and types for the converter sequencer
// Contract
// RL1 - Completion sets the done request bit
// RL2 - Interrupt raised only while enable bit set
// RL3 - Channel field value selects same-numbered input
// RL4 - Software sets pin one analog only
// RL5 - Completion loads result, clears flag, pends
// RL6 - Stay pending until flag written one
// RL7 - Software enables interrupt, then starts
// RL8 - Software reads result only when idle
// RL9 - Software marks chosen channel pins analog
// RL10 - Successive approximation giving eight-bit results
// RL11 - Speed bit selects 62 or 31 cycles
// RL12 - Writing zero stops; flag shows busy
// RL13 - Request bit stays until software clears
`default_nettype none
package adcs_pkg;
    // ************************************************
    // Bus layout
    // ************************************************
    localparam int ADDR_W = 18;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_MODE   = 16'hffbc;
    localparam logic [15:0] IDX_RESULT = 16'hffbd;
    localparam logic [15:0] IDX_GO     = 16'hffbe;
    localparam logic [15:0] IDX_PINFN  = 16'hffef;
    localparam logic [15:0] IDX_INTERRUPT_REQUEST_REG_THREE   = 16'hfff7;
    localparam logic [15:0] IDX_INTERRUPT_ENABLE_REG_THREE  = 16'hfff4;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ************************************************
    // Fields and reset values
    // ************************************************
    localparam int SPEED_BIT = 7;
    localparam int GO_BIT    = 7;
    localparam int REQ_BIT   = 0;
    localparam int IEN_BIT   = 0;
    localparam logic [7:0] MODE_RSVD = 8'h78; // Reserved bits read one
    localparam logic [7:0] GO_RSVD   = 8'h7f;
    localparam logic [7:0] RST_PINFN = 8'h00;
    localparam logic [7:0] RST_RES   = 8'h00;
    // ************************************************
    // Conversion timing in core clock cycles
    // ************************************************
    localparam logic [5:0] CYC_SLOW  = 6'h3e; // 62
    localparam logic [5:0] CYC_FAST  = 6'h1f; // 31
    // Sample phase is two short: start and completion handover each take one flag cycle
    localparam logic [5:0] SMP_SLOW  = 6'h0c; // 12 sample cycles
    localparam logic [5:0] SMP_FAST  = 6'h05;
    localparam logic [5:0] STEP_SLOW = 6'h06; // Cycles per bit trial
    localparam logic [5:0] STEP_FAST = 6'h03;
    localparam logic [7:0] CODE_MID  = 8'h80;
    // Register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000, SEL_MODE = 3'b001, SEL_RES = 3'b010,
        SEL_GO   = 3'b011, SEL_PIN  = 3'b100, SEL_IRR = 3'b101,
        SEL_IEN  = 3'b110
    } adcs_sel_t;
    // Approximation engine states
    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00, SAR_SAMPLE = 2'b01, SAR_TRIAL = 2'b10
    } adcs_sar_state_t;
endpackage
`default_nettype wire

// >>> rtl/adcs_sar_if.sv
// Link between register side and approximation engine
`timescale 1ns/1ps
`default_nettype none
interface adcs_sar_if;
    logic       start;  // One-cycle start pulse
    logic       abort;  // One-cycle stop pulse
    logic       fast;   // Speed select level
    logic       comp;   // Raw comparator level from the pin
    logic       done;   // One-cycle completion pulse
    logic [7:0] result; // Final code, valid with done
    logic [7:0] code;   // Trial code driving the DAC
    modport ctrl (output start, abort, fast, comp, input done, result, code);
    modport core (input start, abort, fast, comp, output done, result, code);
endinterface
`default_nettype wire

// >>> rtl/adcs_sar_core.sv
// Successive-approximation engine with timed bit trials
`timescale 1ns/1ps
`default_nettype none
module adcs_sar_core (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Register side
    adcs_sar_if.core  bus
);
    // Engine state
    typedef struct packed {
        adcs_pkg::adcs_sar_state_t state;
        logic [5:0] ph;     // Cycle within current phase
        logic [5:0] lat;    // Go flag cycles so far, handover included
        logic [2:0] bitidx; // Bit under trial
        logic [7:0] code;   // Trial code
        logic       fast;   // Speed latched at start
        logic       done;
        logic [7:0] result;
        logic       cmp_s1; // Synchroniser stage one
        logic       cmp_s2; // Synchroniser stage two
    } adcs_sar_st_t;

    adcs_sar_st_t st;      // Registered state
    adcs_sar_st_t next_st; // Next state

    // Phase lengths by speed
    function automatic logic [5:0] smp_len(input logic f);
        return f ? adcs_pkg::SMP_FAST : adcs_pkg::SMP_SLOW;
    endfunction
    function automatic logic [5:0] step_len(input logic f);
        return f ? adcs_pkg::STEP_FAST : adcs_pkg::STEP_SLOW;
    endfunction
    function automatic logic [5:0] period(input logic f);
        return f ? adcs_pkg::CYC_FAST : adcs_pkg::CYC_SLOW;
    endfunction

    // ************************************************
    // Next-state logic
    // ************************************************
    // Trial slots of six (slow) or three (fast) cycles let the two-flop comparator path settle
    always_comb begin
        next_st        = st;
        next_st.done   = 1'b0;
        next_st.cmp_s1 = bus.comp;
        next_st.cmp_s2 = st.cmp_s1;
        if (rst) begin
            next_st = '0;
        end else if (bus.abort) begin
            next_st.state = adcs_pkg::SAR_IDLE; // Stop mid-conversion RL12
        end else begin
            case (st.state)
                adcs_pkg::SAR_IDLE: begin
                    if (bus.start) begin
                        next_st.state  = adcs_pkg::SAR_SAMPLE;
                        next_st.ph     = 6'h00;
                        // Flag stood one cycle for the start pulse; completion adds one more
                        next_st.lat    = 6'h02; // RL11
                        next_st.fast   = bus.fast; // RL11
                        next_st.code   = adcs_pkg::CODE_MID; // RL10
                        next_st.bitidx = 3'h7;
                    end
                end
                adcs_pkg::SAR_SAMPLE: begin
                    next_st.lat = st.lat + 6'h01;
                    next_st.ph  = st.ph + 6'h01;
                    if (st.ph == smp_len(st.fast) - 6'h01) begin
                        next_st.state = adcs_pkg::SAR_TRIAL;
                        next_st.ph    = 6'h00;
                    end
                end
                adcs_pkg::SAR_TRIAL: begin
                    next_st.lat = st.lat + 6'h01;
                    next_st.ph  = st.ph + 6'h01;
                    if (st.ph == step_len(st.fast) - 6'h01) begin
                        next_st.ph = 6'h00;
                        // Input below trial code drops the bit RL10
                        if (!st.cmp_s2) begin
                            next_st.code[st.bitidx] = 1'b0;
                        end
                        if (st.bitidx == 3'h0) begin
                            next_st.state  = adcs_pkg::SAR_IDLE;
                            next_st.done   = 1'b1;
                            next_st.result = next_st.code;
                        end else begin
                            next_st.code[st.bitidx - 3'h1] = 1'b1;
                            next_st.bitidx = st.bitidx - 3'h1;
                        end
                    end
                end
                default: begin
                    next_st.state = adcs_pkg::SAR_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign bus.done   = st.done;
    assign bus.result = st.result;
    assign bus.code   = st.code;

    // ************************************************
    // Checks
    // ************************************************
    sequence s_start;
        st.state == adcs_pkg::SAR_IDLE && bus.start && !bus.abort;
    endsequence
    AST_START_MID: assert property (@(posedge core_clk) disable iff (rst) // RL10
        s_start |=> st.code == adcs_pkg::CODE_MID && st.lat == 6'h02)
        else $error("trial did not start at midscale");
    AST_PERIOD: assert property (@(posedge core_clk) disable iff (rst) // RL11
        st.done |-> st.lat == period(st.fast))
        else $error("conversion period wrong");
endmodule
`default_nettype wire

// >>> rtl/adcs_conversion_sequencer.sv
// Register file, bus slave and interrupt for the converter
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adcs_conversion_sequencer (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // AXI4-Lite write address and data
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [adcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    // AXI4-Lite write response
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic [1:0]                      s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [adcs_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    // Analog front end
    input  wire logic                       comp_above,
    output logic [2:0]                      analog_channel_sel,
    output logic [7:0]                      analog_pin_enable,
    output logic [7:0]                      dac_code,
    // Interrupt
    output logic                            irq
);
    // All register-side state
    typedef struct packed {
        logic       speed;      // speed_select_bit
        logic [2:0] chan;       // channel_select_field
        logic       go;         // conversion_go_flag
        logic [7:0] pinfn;      // pin_function_reg
        logic [7:0] result;     // conversion_result_reg
        logic       req;        // convert_done_request
        logic       ien;        // convert_done_irq_enable
        logic       start;      // Start pulse to engine
        logic       abort;      // Stop pulse to engine
        logic       irq;
        logic       aw_held;
        logic [adcs_pkg::ADDR_W-1:0] awaddr;
        logic       w_held;
        logic [7:0] wdata;
        logic       wstrb0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } adcs_top_st_t;

    adcs_top_st_t st;      // Registered state
    adcs_top_st_t next_st; // Next state
    adcs_sar_if   sar ();  // Engine link

    // Address decode, shared by read and write paths
    function automatic adcs_pkg::adcs_sel_t dec(
        input logic [adcs_pkg::ADDR_W-1:0] a);
        if (a[1:0] != 2'h0) begin
            return adcs_pkg::SEL_NONE;
        end
        case (a[adcs_pkg::ADDR_W-1:2])
            adcs_pkg::IDX_MODE:   return adcs_pkg::SEL_MODE;
            adcs_pkg::IDX_RESULT: return adcs_pkg::SEL_RES;
            adcs_pkg::IDX_GO:     return adcs_pkg::SEL_GO;
            adcs_pkg::IDX_PINFN:  return adcs_pkg::SEL_PIN;
            adcs_pkg::IDX_INTERRUPT_REQUEST_REG_THREE:   return adcs_pkg::SEL_IRR;
            adcs_pkg::IDX_INTERRUPT_ENABLE_REG_THREE:  return adcs_pkg::SEL_IEN;
            default:              return adcs_pkg::SEL_NONE;
        endcase
    endfunction

    // ************************************************
    // Write decode
    // ************************************************
    adcs_pkg::adcs_sel_t wsel;    // Register under write
    adcs_pkg::adcs_sel_t rsel;    // Register under read
    logic                wr_fire; // Write performed this cycle
    logic                wen;     // Write with low lane enabled
    logic                go_one;  // Write of one to go flag
    logic                go_zero; // Write of zero to go flag
    logic                done_ok; // Completion while flag set

    always_comb begin
        wsel    = dec(st.awaddr);
        rsel    = dec(s_axi_araddr);
        wr_fire = st.aw_held && st.w_held && !st.bvalid;
        wen     = wr_fire && st.wstrb0;
        go_one  = wen && wsel == adcs_pkg::SEL_GO && st.wdata[adcs_pkg::GO_BIT];
        go_zero = wen && wsel == adcs_pkg::SEL_GO && !st.wdata[adcs_pkg::GO_BIT];
        // Late completion after a stop write is dropped
        done_ok = sar.done && st.go;
    end

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        next_st       = st;
        next_st.start = 1'b0;
        next_st.abort = 1'b0;
        if (rst) begin
            next_st        = '0;
            next_st.pinfn  = adcs_pkg::RST_PINFN;
            next_st.result = adcs_pkg::RST_RES;
        end else begin
            // Capture address and data independently
            if (s_axi_awvalid && s_axi_awready) begin
                next_st.aw_held = 1'b1;
                next_st.awaddr  = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                next_st.w_held = 1'b1;
                next_st.wdata  = s_axi_wdata[7:0];
                next_st.wstrb0 = s_axi_wstrb[0];
            end
            // Perform the write and answer
            if (wr_fire) begin
                next_st.aw_held = 1'b0;
                next_st.w_held  = 1'b0;
                next_st.bvalid  = 1'b1;
                next_st.bresp   = (wsel == adcs_pkg::SEL_NONE) ?
                                  adcs_pkg::RESP_SLVERR : adcs_pkg::RESP_OKAY;
            end
            if (st.bvalid && s_axi_bready) begin
                next_st.bvalid = 1'b0;
            end
            if (wen) begin
                case (wsel)
                    adcs_pkg::SEL_MODE: begin
                        next_st.speed = st.wdata[adcs_pkg::SPEED_BIT];
                        next_st.chan  = st.wdata[2:0]; // RL3
                    end
                    adcs_pkg::SEL_PIN: begin
                        next_st.pinfn = st.wdata;
                    end
                    adcs_pkg::SEL_IEN: begin
                        next_st.ien = st.wdata[adcs_pkg::IEN_BIT];
                    end
                    adcs_pkg::SEL_IRR: begin
                        // Write one clears; a same-cycle completion wins below
                        if (st.wdata[adcs_pkg::REQ_BIT]) begin
                            next_st.req = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // Flag control: stop, or fresh start from pending RL6
            if (go_zero) begin
                next_st.go    = 1'b0; // RL12
                next_st.abort = 1'b1;
            end else if (go_one && !st.go) begin
                next_st.go    = 1'b1; // RL6
                next_st.start = 1'b1;
            end
            // Completion: load, clear flag, request in one step
            if (done_ok) begin
                next_st.result = sar.result; // RL5
                next_st.go     = 1'b0;       // RL5
                next_st.req    = 1'b1;       // RL1 RL13
            end
            next_st.irq = st.req && st.ien; // RL2
            // Read channel; one read at a time
            if (s_axi_arvalid && s_axi_arready) begin
                next_st.rvalid = 1'b1;
                next_st.rresp  = adcs_pkg::RESP_OKAY;
                case (rsel)
                    adcs_pkg::SEL_MODE: next_st.rdata = adcs_pkg::MODE_RSVD |
                        {st.speed, 4'h0, st.chan};
                    adcs_pkg::SEL_RES:  next_st.rdata = st.result;
                    adcs_pkg::SEL_GO:   next_st.rdata = adcs_pkg::GO_RSVD |
                        {st.go, 7'h00}; // RL12
                    adcs_pkg::SEL_PIN:  next_st.rdata = 8'h00; // Write-only
                    adcs_pkg::SEL_IRR:  next_st.rdata = {7'h00, st.req};
                    adcs_pkg::SEL_IEN:  next_st.rdata = {7'h00, st.ien};
                    default: begin
                        next_st.rdata = 8'h00;
                        next_st.rresp = adcs_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (st.rvalid && s_axi_rready) begin
                next_st.rvalid = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    // ************************************************
    // Engine and outputs
    // ************************************************
    assign sar.start = st.start;
    assign sar.abort = st.abort;
    assign sar.fast  = st.speed; // RL11
    assign sar.comp  = comp_above;

    adcs_sar_core u_core (
        .core_clk (core_clk),
        .rst      (rst),
        .bus      (sar.core)
    );

    // Handshake readies are combinational
    assign s_axi_awready      = !st.aw_held && !st.bvalid;
    assign s_axi_wready       = !st.w_held && !st.bvalid;
    assign s_axi_bvalid       = st.bvalid;
    assign s_axi_bresp        = st.bresp;
    assign s_axi_arready      = !st.rvalid;
    assign s_axi_rvalid       = st.rvalid;
    assign s_axi_rdata        = {24'h000000, st.rdata};
    assign s_axi_rresp        = st.rresp;
    assign analog_channel_sel = st.chan; // RL3
    assign analog_pin_enable  = st.pinfn;
    assign dac_code           = sar.code;
    assign irq                = st.irq;

    // ************************************************
    // Checks
    // ************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_done;
        done_ok;
    endsequence
    AST_DONE_REQ: assert property (s_done |=> st.req) // RL1
        else $error("completion did not set request");
    AST_IRQ_MASK: assert property (!st.ien |=> !irq) // RL2
        else $error("interrupt raised while disabled");
    AST_IRQ_RAISE: assert property (st.req && st.ien |=> irq) // RL2
        else $error("enabled request raised no interrupt");
    AST_CHAN_ROUTE: assert property ($changed(analog_channel_sel) |-> // RL3
        $past(wen && wsel == adcs_pkg::SEL_MODE))
        else $error("channel changed without mode write");
    AST_DONE_LOAD: assert property (s_done |=> !st.go && // RL5
        st.result == $past(sar.result))
        else $error("completion step incomplete");
    AST_PENDING: assert property (!st.go && !go_one |=> !st.go) // RL6
        else $error("left pending without start write");
    AST_STOP: assert property (go_zero |=> !st.go ##1 !sar.done) // RL12
        else $error("stop write did not stop");
    AST_STICKY: assert property (st.req && !(wen && // RL13
        wsel == adcs_pkg::SEL_IRR && st.wdata[adcs_pkg::REQ_BIT]) |=> st.req)
        else $error("request dropped without clear");
endmodule
`default_nettype wire

// >>> verification/adcs_conversion_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_conversion_sequencer_tb;
    // ********************************
    // Signals
    // ********************************
    localparam int LIMIT = 20000;   // Whole run fits well inside this
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        awv      = 1'b0;
    logic        wv       = 1'b0;
    logic        bry      = 1'b0;
    logic        arv      = 1'b0;
    logic        rry      = 1'b0;
    logic [17:0] awa      = '0;
    logic [17:0] ara      = '0;
    logic [31:0] wd       = '0;
    logic [3:0]  ws       = '0;
    logic [7:0]  vin      = '0;    // Analog level seen by the comparator
    logic        awr, wrdy, bv, arr, rv, irq, comp;
    logic [1:0]  br, rr;
    logic [31:0] rdd;
    logic [7:0]  dac, pins;
    logic [2:0]  chs;
    logic [33:0] rq[$];            // Expected {rresp, rdata}
    logic [1:0]  bq[$];            // Expected bresp
    logic [31:0] rng      = 32'h0000a31c;
    logic [31:0] tmp;
    logic [7:0]  v, old;
    int          err_count    = 0;
    int          total_checks = 0;
    int          cyc          = 0;
    int          lat, i;

    // Comparator: high while the input sits above the trial code
    assign comp = (vin > dac);

    adcs_conversion_sequencer u_dut (
        .core_clk(core_clk), .rst(rst),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdd), .s_axi_rresp(rr),
        .comp_above(comp), .analog_channel_sel(chs), .analog_pin_enable(pins),
        .dac_code(dac), .irq(irq)
    );

    // Clock, 10 ns period
    always #5 core_clk = ~core_clk;

    // ********************************
    // Helpers
    // ********************************
    task automatic conclude();
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Case equality so that an unknown never matches
    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Reference approximation: keep each trial bit while input is above
    function automatic logic [7:0] sar(input logic [7:0] a);
        logic [7:0] c;
        c = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            if (a > (c | (8'h01 << b))) c = c | (8'h01 << b);
        end
        return c;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wrt(input logic [15:0] x, input logic [7:0] d,
                       input logic [1:0] r = adcs_pkg::RESP_OKAY);
        bq.push_back(r);
        @(posedge core_clk);
        awv <= 1'b1;
        awa <= {x, 2'b00};
        wv  <= 1'b1;
        wd  <= {24'h000000, d};
        ws  <= 4'hf;
        bry <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bv) break;
        end
        bry <= 1'b0;
    endtask

    // Read: note the expected word, then wait for the answer
    task automatic rdt(input logic [15:0] x, input logic [7:0] d,
                       input logic [1:0] r = adcs_pkg::RESP_OKAY);
        rq.push_back({r, 24'h000000, d});
        @(posedge core_clk);
        arv <= 1'b1;
        ara <= {x, 2'b00};
        rry <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        rry <= 1'b0;
    endtask

    // Watcher: each completed response takes the oldest note
    always @(posedge core_clk) begin
        if (rv && rry) check("read", {rr, rdd}, rq.pop_front());
        if (bv && bry) check("bresp", {32'h0, br}, {32'h0, bq.pop_front()});
    end

    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            conclude();
        end
    end

    // ********************************
    // Scenarios
    // ********************************
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values and an unmapped place
        rdt(adcs_pkg::IDX_MODE, adcs_pkg::MODE_RSVD);
        rdt(adcs_pkg::IDX_GO, adcs_pkg::GO_RSVD);
        rdt(adcs_pkg::IDX_RESULT, adcs_pkg::RST_RES);
        rdt(adcs_pkg::IDX_PINFN, 8'h00);
        rdt(adcs_pkg::IDX_INTERRUPT_REQUEST_REG_THREE, 8'h00);
        rdt(adcs_pkg::IDX_INTERRUPT_ENABLE_REG_THREE, 8'h00);
        rdt(16'h0000, 8'h00, adcs_pkg::RESP_SLVERR);
        wrt(16'h0000, 8'hff, adcs_pkg::RESP_SLVERR);
        // Every channel code and its pin
        for (i = 0; i < 8; i++) begin
            wrt(adcs_pkg::IDX_PINFN, 8'h01 << i);
            wrt(adcs_pkg::IDX_MODE, 8'(i));
            check("chan", 34'(chs), 34'(i));
            check("pins", 34'(pins), 34'(8'h01 << i));
        end
        wrt(adcs_pkg::IDX_PINFN, 8'h02);
        // Both speeds, enabled and masked, boundary and random levels
        for (i = 0; i < 4; i++) begin
            tmp = xs();
            v = (i == 2) ? 8'h00 : (i == 3) ? 8'hff : tmp[7:0];
            vin <= v;
            wrt(adcs_pkg::IDX_INTERRUPT_REQUEST_REG_THREE, 8'h01);
            tick(1);
            check("irq clear", 34'(irq), 34'h0);
            wrt(adcs_pkg::IDX_INTERRUPT_ENABLE_REG_THREE, {7'h00, ~i[1]});
            wrt(adcs_pkg::IDX_MODE, {i[0], 7'h01});
            wrt(adcs_pkg::IDX_GO, 8'h80);
            lat = 0;
            while (irq !== 1'b1 && lat < 100) begin
                @(posedge core_clk);
                lat++;
            end
            if (!i[1]) check("latency", 34'(lat), i[0] ? 34'd32 : 34'd63);
            else check("irq masked", 34'(irq), 34'h0);
            rdt(adcs_pkg::IDX_RESULT, sar(v));
            rdt(adcs_pkg::IDX_GO, adcs_pkg::GO_RSVD);
            rdt(adcs_pkg::IDX_INTERRUPT_REQUEST_REG_THREE, 8'h01);
            wrt(adcs_pkg::IDX_INTERRUPT_ENABLE_REG_THREE, 8'h01);
            tick(1);
            check("irq", 34'(irq), 34'h1);
            old = sar(v);
        end
        // Restart with request set, then stop mid-run
        vin <= 8'h5a;
        wrt(adcs_pkg::IDX_GO, 8'h80);
        rdt(adcs_pkg::IDX_INTERRUPT_REQUEST_REG_THREE, 8'h01);
        rdt(adcs_pkg::IDX_GO, 8'hff);
        wrt(adcs_pkg::IDX_GO, 8'h00);
        rdt(adcs_pkg::IDX_GO, adcs_pkg::GO_RSVD);
        wrt(adcs_pkg::IDX_INTERRUPT_REQUEST_REG_THREE, 8'h01);
        tick(80);
        check("irq stop", 34'(irq), 34'h0);
        rdt(adcs_pkg::IDX_INTERRUPT_REQUEST_REG_THREE, 8'h00);
        rdt(adcs_pkg::IDX_RESULT, old);
        rdt(adcs_pkg::IDX_GO, adcs_pkg::GO_RSVD);
        conclude();
    end
endmodule
`default_nettype wire
